/* File: rtl/cpl_defines.svh */
// constants for the control and host pin logic block
`ifndef CPL_DEFINES_SVH
`define CPL_DEFINES_SVH
`define CPL_SYNC_STAGES 2
`define CPL_INSEL_W 2
`define CPL_INSEL_RST 2'h0
`define CPL_IFSEL_I2C 1'h1
`define CPL_IFSEL_SPI 1'h0
`define CPL_SYNC_OFF 1'h1
`define CPL_STATUS_W 4
`endif

/* File: rtl/cpl_pins.sv */
// control and host pin logic: serial pin sharing and control/status pins
`timescale 1ns/1ps
`include "cpl_defines.svh"
module cpl_pins #(
  parameter int INSEL_W  = `CPL_INSEL_W,
  parameter int STATUS_W = `CPL_STATUS_W
) (
  input  wire logic                clk,
  input  wire logic                rstn,
  input  wire logic                resetNPin,
  input  wire logic                powerdownN,
  input  wire logic                outEnableN,
  input  wire logic                syncN,
  input  wire logic [INSEL_W-1:0]  inSelPins,
  input  wire logic                i2cSel,
  input  wire logic                spiFourWire,
  input  wire logic                manualSel,
  input  wire logic                sclkIn,
  input  wire logic                addr0OrChipSelN,
  input  wire logic                addr1OrSpiOutIn,
  input  wire logic                sdaIn,
  input  wire logic                coreSdaOut,
  input  wire logic                coreSdaDrive,
  input  wire logic                coreSpiOut,
  input  wire logic                pllLocked,
  input  wire logic [STATUS_W-1:0] devStatus,
  input  wire logic                irqClear,
  input  wire logic [INSEL_W-1:0]  regInSel,
  output logic                     serialClk,
  output logic                     chipSelN,
  output logic [1:0]               devAddrBits,
  output cpl_pkg::cpl_mode_t       hostMode,
  output logic                     sdaOut,
  output logic                     sdaOen,
  output logic                     addr1OrSpiOutOut,
  output logic                     addr1OrSpiOutOen,
  output logic                     irqN,
  output logic                     lowPower,
  output logic                     coreResetN,
  output logic                     clkOutEnable,
  output logic                     lockStatus,
  output logic                     dividerReset,
  output logic [INSEL_W-1:0]       activeInput
);
  localparam int CW = 4 + INSEL_W + 1 + 1; // control bundle width
  localparam logic [CW-1:0] CRST = {1'h1, 1'h1, 1'h0, `CPL_SYNC_OFF, `CPL_INSEL_RST, `CPL_IFSEL_I2C, 1'h0};

  logic [CW-1:0]         ctlRaw;     // raw control pins
  logic [CW-1:0]         ctlSync;    // synchronised control pins
  logic                  rstSync;    // synced reset pin, active low
  logic                  pdnSync;    // synced power-down, active low
  logic                  oenSync;    // synced output enable, active low
  logic                  syncSync;   // synced divider sync, active low
  logic [INSEL_W-1:0]    selSync;    // synced input select
  logic                  ifSync;     // synced interface select
  logic                  spi4Sync;   // synced 4-wire option
  logic [STATUS_W-1:0]   status_ff;  // last seen status
  logic                  statusSeen_ff; // status_ff holds a real sample
  logic                  intRst;     // internal reset, the synced reset pin alone, active low
  cpl_pkg::cpl_mode_t    nxt_mode;   // decoded interface mode

  assign ctlRaw = {resetNPin, powerdownN, outEnableN, syncN, inSelPins, i2cSel, spiFourWire};

  cpl_sync #(
    .W       (CW),
    .RST_VAL (CRST)
  ) u_sync (
    .clk  (clk),
    .rstn (rstn),
    .din  (ctlRaw),
    .dout (ctlSync)
  );

  assign {rstSync, pdnSync, oenSync, syncSync, selSync, ifSync, spi4Sync} = ctlSync;
  // pin reset acts through the synchroniser, so it takes two edges to reach intRst and a third to reach the outputs
  assign intRst = rstSync;

  always_comb
  begin
    if (ifSync == `CPL_IFSEL_I2C)
      nxt_mode = cpl_pkg::CPL_I2C;
    else if (spi4Sync)
      nxt_mode = cpl_pkg::CPL_SPI4;
    else
      nxt_mode = cpl_pkg::CPL_SPI3;
  end

  // mode register, reset to i2c (pull-up default)
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      hostMode <= cpl_pkg::CPL_I2C;
    else if (!intRst)
      hostMode <= cpl_pkg::CPL_I2C;
    else
    begin
      case (nxt_mode)
        cpl_pkg::CPL_I2C:  hostMode <= cpl_pkg::CPL_I2C;
        cpl_pkg::CPL_SPI3: hostMode <= cpl_pkg::CPL_SPI3;
        cpl_pkg::CPL_SPI4: hostMode <= cpl_pkg::CPL_SPI4;
        default:           hostMode <= cpl_pkg::CPL_I2C;
      endcase
    end
  end

  // serial clock registered straight through; the serial engine samples it
  // serial clock, plus chip select and address straps by mode
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      serialClk   <= 1'h1;
      chipSelN    <= 1'h1;
      devAddrBits <= 2'h0;
    end
    else
    begin
      serialClk <= sclkIn;
      if (hostMode == cpl_pkg::CPL_I2C)
      begin
        chipSelN       <= 1'h1;
        devAddrBits[0] <= addr0OrChipSelN;
        devAddrBits[1] <= addr1OrSpiOutIn;
      end
      else
      begin
        chipSelN    <= addr0OrChipSelN;
        devAddrBits <= devAddrBits;
      end
    end
  end

  // data pin drivers; enables are active low, high means released
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      sdaOut           <= 1'h0;
      sdaOen           <= 1'h1;
      addr1OrSpiOutOut <= 1'h0;
      addr1OrSpiOutOen <= 1'h1;
    end
    else
    begin
      sdaOut <= coreSdaOut;
      sdaOen <= !(coreSdaDrive && hostMode != cpl_pkg::CPL_SPI4);
      addr1OrSpiOutOut <= coreSpiOut;
      // spi4 read out; only while selected so a bus can be shared
      addr1OrSpiOutOen <= !(hostMode == cpl_pkg::CPL_SPI4 && !addr0OrChipSelN && coreSdaDrive);
    end
  end

  // first sample after reset only primes status_ff; without it the
  // reset value of status_ff would look like a change and raise a
  // false irq whenever the status vector is non-zero at release
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      statusSeen_ff <= 1'h0;
    else
      statusSeen_ff <= 1'h1;
  end

  // status change irq; sticky until cleared, new change wins
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      status_ff <= '0;
      irqN      <= 1'h1;
    end
    else if (!intRst)
    begin
      status_ff <= devStatus;
      irqN      <= 1'h1;
    end
    else
    begin
      status_ff <= devStatus;
      // a change in the same cycle as a clear keeps the irq low
      if (statusSeen_ff && devStatus != status_ff)
        irqN <= 1'h0;
      else if (irqClear)
        irqN <= 1'h1;
    end
  end

  // control outputs
  // full reset
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      coreResetN   <= 1'h0;
      lowPower     <= 1'h0;
      clkOutEnable <= 1'h0;
      lockStatus   <= 1'h0;
      dividerReset <= 1'h1;
      activeInput  <= `CPL_INSEL_RST;
    end
    else
    begin
      coreResetN <= intRst;
      lowPower <= !pdnSync;
      clkOutEnable <= intRst && !oenSync;
      // lock status; forced low while held in reset
      lockStatus <= intRst && pllLocked;
      dividerReset <= !intRst || !syncSync;
      if (!intRst)
        activeInput <= `CPL_INSEL_RST;
      else if (manualSel)
        activeInput <= selSync;
      else
        activeInput <= regInSel;
    end
  end

  // checks; all sampled on clk, all quiet while rstn is low
  rst_outs_a: assert property (@(posedge clk) disable iff (!rstn)
    !rstSync |=> !clkOutEnable && !coreResetN) else $error("outputs live in reset");
  // outputs come back once oe is low and reset is gone
  oe_on_a: assert property (@(posedge clk) disable iff (!rstn)
    rstSync && !oenSync |=> clkOutEnable) else $error("outputs not enabled");
  // irq must stay low until a clear arrives
  irq_hold_a: assert property (@(posedge clk) disable iff (!rstn)
    rstSync && !irqN && !irqClear |=> !irqN) else $error("irq dropped early");
  // address straps are frozen while in spi
  addr_hold_a: assert property (@(posedge clk) disable iff (!rstn)
    hostMode != cpl_pkg::CPL_I2C |=> $stable(devAddrBits)) else $error("addr moved in spi");
  // select follows the shared pin in spi
  cs_follow_a: assert property (@(posedge clk) disable iff (!rstn)
    hostMode != cpl_pkg::CPL_I2C |=> chipSelN == $past(addr0OrChipSelN)) else $error("select lost");
  // spi4 read data drives the shared pin when selected
  spi4_out_a: assert property (@(posedge clk) disable iff (!rstn)
    hostMode == cpl_pkg::CPL_SPI4 && !addr0OrChipSelN && coreSdaDrive |=> !addr1OrSpiOutOen)
    else $error("spi4 out not driven");
  // register select used when not pin controlled
  reg_sel_a: assert property (@(posedge clk) disable iff (!rstn)
    rstSync && !manualSel |=> activeInput == $past(regInSel)) else $error("reg select wrong");
  outen_gate_a: assert property (@(posedge clk) disable iff (!rstn)
    oenSync |=> !clkOutEnable) else $error("outputs enabled with oe high");
  reset_out_a: assert property (@(posedge clk) disable iff (!rstn)
    !rstSync |=> !clkOutEnable) else $error("clock out enabled in reset");
  core_reset_a: assert property (@(posedge clk) disable iff (!rstn)
    !rstSync |=> !coreResetN && dividerReset) else $error("reset not passed");
  lock_pin_a: assert property (@(posedge clk) disable iff (!rstn)
    rstSync && pllLocked |=> lockStatus) else $error("lock not shown");
  pdn_mode_a: assert property (@(posedge clk) disable iff (!rstn)
    lowPower == !$past(pdnSync)) else $error("low power wrong");
  sync_div_a: assert property (@(posedge clk) disable iff (!rstn)
    !syncSync |=> dividerReset) else $error("divider not reset");
  irq_event_a: assert property (@(posedge clk) disable iff (!rstn)
    rstSync && statusSeen_ff && devStatus != status_ff |=> !irqN) else $error("irq missed");
  spi4_sda_a: assert property (@(posedge clk) disable iff (!rstn)
    hostMode == cpl_pkg::CPL_SPI4 |=> sdaOen) else $error("sda driven in spi4");
  i2c_out_a: assert property (@(posedge clk) disable iff (!rstn)
    hostMode == cpl_pkg::CPL_I2C |=> addr1OrSpiOutOen) else $error("addr1 driven in i2c");
  cs_idle_a: assert property (@(posedge clk) disable iff (!rstn)
    hostMode == cpl_pkg::CPL_I2C |=> chipSelN) else $error("select in i2c");
  mode_sel_a: assert property (@(posedge clk) disable iff (!rstn)
    rstSync && ifSync |=> hostMode == cpl_pkg::CPL_I2C) else $error("mode wrong");
  man_sel_a: assert property (@(posedge clk) disable iff (!rstn)
    rstSync && manualSel |=> activeInput == $past(selSync)) else $error("input select wrong");
  sclk_pass_a: assert property (@(posedge clk) disable iff (!rstn)
    serialClk == $past(sclkIn)) else $error("serial clock lost");
  sync_lat_a: assert property (@(posedge clk) disable iff (!rstn)
    pdnSync == $past(powerdownN, 2)) else $error("sync latency wrong");

  cov_irq_c: cover property (@(posedge clk) disable iff (!rstn) $fell(irqN));
  cov_spi4_c: cover property (@(posedge clk) disable iff (!rstn) hostMode == cpl_pkg::CPL_SPI4 && !addr1OrSpiOutOen);
  cov_lock_c: cover property (@(posedge clk) disable iff (!rstn) $rose(lockStatus));
  cov_pdn_c: cover property (@(posedge clk) disable iff (!rstn) $rose(lowPower));
  cov_div_c: cover property (@(posedge clk) disable iff (!rstn) $rose(dividerReset));
endmodule

/* File: rtl/cpl_pkg.sv */
// types for the control and host pin logic block
package cpl_pkg;
  // host interface mode, gray along i2c -> spi3 -> spi4
  typedef enum logic [1:0]
  {
    CPL_I2C  = 2'h0,
    CPL_SPI3 = 2'h1,
    CPL_SPI4 = 2'h3
  } cpl_mode_t;
endpackage

/* File: rtl/cpl_sync.sv */
// parameterised two-flop synchroniser for a bus of level inputs
`timescale 1ns/1ps
`include "cpl_defines.svh"
module cpl_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         clk,
  input  wire logic         rstn,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] meta_ff; // first stage, read only by the second

  // double registering; first flop feeds nothing but the second
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      meta_ff <= RST_VAL;
      dout    <= RST_VAL;
    end
    else
    begin
      meta_ff <= din;
      dout    <= meta_ff;
    end
  end
endmodule

/* File: tb/cpl_host_model.sv */
// host-side partner: serial clock source and resolved pin wires
`timescale 1ns/1ps
module cpl_host_model (
  input  wire logic clk,
  input  wire logic runSclk,    // clock only inside frames
  input  wire logic hostSda,    // host data, 1 = released
  input  wire logic addr1Strap, // strap level on the addr1 pin
  input  wire logic sdaOut,
  input  wire logic sdaOen,
  input  wire logic spiOut,
  input  wire logic spiOen,
  output logic      sclkPin,
  output logic      sdaPin,
  output logic      addr1Pin
);
  always_ff @(posedge clk)
  begin
    sclkPin <= runSclk ? ~sclkPin : 1'h1;  // parks high between frames
  end
  // wired-and data line with pull-up, so released reads high
  assign sdaPin = (sdaOen | sdaOut) & hostSda;
  // strap shows whenever the device lets go of the pin
  assign addr1Pin = spiOen ? addr1Strap : spiOut;
endmodule

/* File: tb/testbench.sv */
// self-checking bench for the control and host pin logic
`timescale 1ns/1ps
module testbench;
  logic clk = 0, rstn = 0, rNP = 1, pdN = 1, oeN = 0, syN = 1, i2cSel = 1, spi4 = 0, manSel = 0;
  logic a0 = 1, strap = 0, cSda = 0, cDrv = 0, cSpi = 1, lock = 1, irqClr = 0, runSclk = 0;
  logic [1:0] pinSel = 0, regSel = 0;
  logic [3:0] devSt = 0;
  logic sclkPin, sdaPin, a1Pin, sclkPrev, serialClk, chipSelN, sdaOut, sdaOen, a1Out, a1Oen, irqN;
  logic lowPower, coreResetN, clkOutEnable, lockStatus, dividerReset;
  logic [1:0] devAddrBits, activeInput;
  cpl_pkg::cpl_mode_t hostMode;
  int failCount = 0, numChecks = 0, cycles = 0;
  logic [9:0] rows [5] = '{10'h375, 10'h27D, 10'h392, 10'h162, 10'h354};  // inputs, then outputs
  always #5 clk = ~clk;
  always @(posedge clk) sclkPrev <= sclkPin;
  cpl_host_model host_u (.clk(clk), .runSclk(runSclk), .hostSda(1'h1), .addr1Strap(strap),
    .sdaOut(sdaOut), .sdaOen(sdaOen), .spiOut(a1Out), .spiOen(a1Oen), .sclkPin(sclkPin),
    .sdaPin(sdaPin), .addr1Pin(a1Pin));
  cpl_pins dut_u (.clk(clk), .rstn(rstn), .resetNPin(rNP), .powerdownN(pdN), .outEnableN(oeN),
    .syncN(syN), .inSelPins(pinSel), .i2cSel(i2cSel), .spiFourWire(spi4), .manualSel(manSel),
    .sclkIn(sclkPin), .addr0OrChipSelN(a0), .addr1OrSpiOutIn(a1Pin), .sdaIn(sdaPin),
    .coreSdaOut(cSda), .coreSdaDrive(cDrv), .coreSpiOut(cSpi), .pllLocked(lock),
    .devStatus(devSt), .irqClear(irqClr), .regInSel(regSel), .serialClk(serialClk),
    .chipSelN(chipSelN), .devAddrBits(devAddrBits), .hostMode(hostMode), .sdaOut(sdaOut),
    .sdaOen(sdaOen), .addr1OrSpiOutOut(a1Out), .addr1OrSpiOutOen(a1Oen), .irqN(irqN),
    .lowPower(lowPower), .coreResetN(coreResetN), .clkOutEnable(clkOutEnable),
    .lockStatus(lockStatus), .dividerReset(dividerReset), .activeInput(activeInput));
  // compare one observed value against its expectation
  task chk(string nm, logic [4:0] seen, logic [4:0] exp);
    numChecks++;
    if (seen !== exp)
    begin
      failCount++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task cyc(int n);
    repeat (n) @(negedge clk);
  endtask
  // single exit, also taken by the hang guard
  task tally_and_finish;
    $display("checks %0d mismatches %0d", numChecks, failCount);
    if (failCount == 0 && numChecks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // hang guard, far above the roughly 90 cycles needed
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      failCount++;
      tally_and_finish();
    end
  end
  initial
  begin
    cyc(10);
    rstn = 1;
    foreach (rows[i])
    begin
      {rNP, pdN, oeN, syN, lock} = rows[i][9:5];
      cyc(4);
      chk("ctrl", {coreResetN, lowPower, clkOutEnable, dividerReset, lockStatus}, rows[i][4:0]);
    end
    $display("control rows done");
    oeN = 1;
    cyc(2);
    chk("oe early", clkOutEnable, 1);
    cyc(1);
    chk("oe late", clkOutEnable, 0);
    oeN = 0;
    cDrv = 1;
    cyc(6);
    chk("mode", hostMode, cpl_pkg::CPL_I2C);
    chk("addr", devAddrBits, 2'h1);
    chk("sda i2c", sdaOen, 0);
    i2cSel = 0;
    cyc(4);
    a0 = 0;
    cyc(2);
    chk("mode", hostMode, cpl_pkg::CPL_SPI3);
    chk("cs", chipSelN, 0);
    chk("addr held", devAddrBits, 2'h1);
    chk("a1 spi3", a1Oen, 1);
    spi4 = 1;
    cyc(6);
    chk("mode", hostMode, cpl_pkg::CPL_SPI4);
    chk("sda spi4", sdaOen, 1);
    chk("a1 drive", {a1Oen, a1Pin}, 2'h1);
    $display("pin sharing done");
    runSclk = 1;
    repeat (4)
    begin
      cyc(1);
      chk("sclk", serialClk, sclkPrev);
    end
    runSclk = 0;
    // status change sets irq until cleared
    devSt = 4'h5;
    cyc(3);
    chk("irq set", irqN, 0);
    irqClr = 1;
    cyc(1);
    irqClr = 0;
    cyc(2);
    chk("irq clr", irqN, 1);
    // every manual select code, then register select
    manSel = 1;
    regSel = 2'h1;
    for (int s = 0; s < 4; s++)
    begin
      pinSel = 2'(s);
      cyc(4);
      chk("insel", activeInput, 5'(s));
    end
    manSel = 0;
    cyc(4);
    chk("regsel", activeInput, 2'h1);
    // reset in mid-run acts at once
    rstn = 0;
    cyc(1);
    chk("rst", {coreResetN, clkOutEnable, irqN, hostMode}, 5'h04);
    rstn = 1;
    cyc(4);
    chk("rst rel", {coreResetN, clkOutEnable, irqN, hostMode}, 5'h1F);
    $display("hand tests done");
    tally_and_finish();
  end
endmodule
